// File: isa_slave_consts.svh
`ifndef ISA_SLAVE_CONSTS_SVH
`define ISA_SLAVE_CONSTS_SVH

// ****************************************
// I/O decode (10-bit ISA I/O addresses)
// ****************************************
`define IO_SEQ_BASE      10'h3c4  // Sequencer index/data pair
`define IO_GFX_BASE      10'h3ce  // Graphics index/data pair
`define IO_CRT_MONO_BASE 10'h3b4  // CRT pair, mono map
`define IO_CRT_COLR_BASE 10'h3d4  // CRT pair, colour map
`define IO_STAT_MONO     10'h3ba  // Input status 1, mono map
`define IO_STAT_COLR     10'h3da  // Input status 1, colour map
`define IO_RANGE_LO      10'h3b0  // Lowest register group address
`define IO_RANGE_HI      10'h3df  // Highest register group address

// ****************************************
// Memory decode on address bits 23:17
// ****************************************
`define MEM_DISP_HI      7'h05    // A000:0-BFFF:F display window
`define MEM_BIOS_HI      7'h06    // C000:0-DFFF:F, narrowed below
`define MEM_BIOS_MID     2'h0     // Bits 16:15 zero: C000:0-C7FF:F

// ****************************************
// Reset values
// ****************************************
`define RST_DATA         16'h0000 // Data bus output latch

`endif

// File: isa_slave_pkg.sv
`default_nettype none
package isa_slave_pkg;

  // ****************************************
  // Bus-side groups
  // ****************************************
  // Address phase of an ISA cycle
  typedef struct packed {
    logic [23:17] adr_hi;                // Memory decode bits
    logic [16:2]  adr;                   // Word address
    logic         byte_lane3_enable_n;   // Carries A1 on ISA
    logic         byte_lane2_enable_n;   // Carries A0 on ISA
    logic         aen;                   // DMA cycle, high active
  } isa_addr_t;

  // Command strobes, all active low
  typedef struct packed {
    logic ior_n;                   // I/O read
    logic smemr_n;                 // Memory read
    logic mem_write_strobe_in_n;   // Memory write
  } isa_strobe_t;

  // One posted display-memory write
  typedef struct packed {
    logic [16:0] addr;   // {adr[16:2], A1, A0}
    logic [15:0] data;   // Captured system data
  } wbuf_entry_t;

  // Cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_RD_HOLD,
    ST_WR,
    ST_BIOS,
    ST_IO_RD
  } slave_state_t;

endpackage : isa_slave_pkg

`default_nettype wire

// File: isa_write_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module isa_write_buffer #(
  parameter int DEPTH = 4   // Entries, a power of two, at least 2
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // Fill side
  input  wire logic                       push_i,
  input  wire isa_slave_pkg::wbuf_entry_t push_data_i,
  output var  logic                       full_o,
  // Drain side
  output var  logic                       valid_o,
  output isa_slave_pkg::wbuf_entry_t      data_o,
  input  wire logic                       pop_i
);
  import isa_slave_pkg::*;

  localparam int AW = $clog2(DEPTH);

  wbuf_entry_t  mem_q [DEPTH];   // Entry storage, no reset needed
  logic [AW:0]  wr_ptr_ff;       // Write pointer, wrap bit on top
  logic [AW:0]  rd_ptr_ff;       // Read pointer, wrap bit on top
  logic         full_ff;         // Registered full flag
  logic         empty_ff;        // Registered empty flag

  // Guarded handshakes so a stray push or pop cannot corrupt pointers
  wire          do_push  = push_i & ~full_ff;
  wire          do_pop   = pop_i & ~empty_ff;
  wire [AW:0]   nxt_wr   = do_push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
  wire [AW:0]   nxt_rd   = do_pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
  wire          nxt_full = (nxt_wr[AW] != nxt_rd[AW]) && (nxt_wr[AW-1:0] == nxt_rd[AW-1:0]);

  // Pointer and flag registers; full feeds the ready logic
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      full_ff   <= 1'b0;
      empty_ff  <= 1'b1;
    end else begin
      wr_ptr_ff <= nxt_wr;
      rd_ptr_ff <= nxt_rd;
      full_ff   <= nxt_full;           // see RQ13
      empty_ff  <= (nxt_wr == nxt_rd);
    end
  end

  // Storage write
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem_q[wr_ptr_ff[AW-1:0]] <= push_data_i;
    end
  end

  assign full_o  = full_ff;
  assign valid_o = ~empty_ff;
  assign data_o  = mem_q[rd_ptr_ff[AW-1:0]];

endmodule : isa_write_buffer

`default_nettype wire

// File: isa_slave_ready_and_io_decode.sv
// How it works
// RQ1: Ready held high in I/O, ROM reads.
// RQ2: Display read: ready low when read strobe falls.
// RQ3: Data ready: ready high, then release at end.
// RQ4: Write with room: ready high at once.
// RQ5: Write with full buffer: low until room.
// RQ6: Host waits while ready stays low.
// RQ7: 16-bit claim only pulled low, never high.
// RQ8: Claim decoded from address, lanes, AEN.
// RQ9: Claim covers sequencer, graphics, CRT, status ports.
// RQ10: I/O read in range drives register data.
// RQ11: Host starts memory reads with read strobe.
// RQ12: Write strobe rising edge latches data, posts it.
// RQ13: Buffer gives full flag and drain done.
// RQ14: Nothing driven outside decoded ranges.
`timescale 1ns/1ps
`default_nettype none
`include "isa_slave_consts.svh"

module isa_slave_ready_and_io_decode #(
  parameter int WBUF_DEPTH = 4   // Posted write entries
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // ISA address phase and strobes
  input  wire isa_slave_pkg::isa_addr_t   isa_addr_i,
  input  wire isa_slave_pkg::isa_strobe_t isa_strobe_i,
  // ISA data bus, split three-state
  input  wire logic [15:0]                sd_i,
  output logic [15:0]                     sd_o,
  output logic                            sd_oe_o,
  // IOCHRDY, three-state
  output logic                            iochrdy_o,
  output logic                            iochrdy_oe_o,
  // IOCS16*, open collector
  output logic                            io16_claim_out_o,
  output logic                            io16_claim_out_oe_o,
  // Register groups, read side
  output logic                            reg_rd_strobe_o,
  output logic [9:0]                      reg_rd_addr_o,
  input  wire logic [15:0]                reg_rd_data_i,
  // Display memory, read side
  output logic                            dm_rd_req_o,
  output logic [16:0]                     dm_rd_addr_o,
  input  wire logic                       dm_rd_valid_i,
  input  wire logic [15:0]                dm_rd_data_i,
  // Display memory, posted write side
  output logic                            dm_wr_valid_o,
  output isa_slave_pkg::wbuf_entry_t      dm_wr_entry_o,
  input  wire logic                       dm_wr_done_i
);
  import isa_slave_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************

  // Same index/data pair: ignore A0
  function automatic logic pair_hit(input logic [9:0] addr, input logic [9:0] base);
    pair_hit = (addr[9:1] == base[9:1]);
  endfunction : pair_hit

  wire [9:0]  io_addr    = {isa_addr_i.adr[9:2], isa_addr_i.byte_lane3_enable_n,
                            isa_addr_i.byte_lane2_enable_n};   // Full 10-bit I/O address
  wire        io_upper0  = (isa_addr_i.adr[16:10] == 7'h00);   // Alias guard above 3FF
  wire        io_qual    = ~isa_addr_i.aen & io_upper0;        // DMA cycles are not ours

  // Claim decode is purely combinational; one flop stage before the pin
  wire        io16_hit   = io_qual & (pair_hit(io_addr, `IO_SEQ_BASE)
                                    | pair_hit(io_addr, `IO_GFX_BASE)
                                    | pair_hit(io_addr, `IO_CRT_MONO_BASE)
                                    | pair_hit(io_addr, `IO_CRT_COLR_BASE)
                                    | (io_addr == `IO_STAT_MONO)
                                    | (io_addr == `IO_STAT_COLR));   // see RQ8 see RQ9

  // Whole register group window for reads
  wire        io_range   = io_qual & (io_addr >= `IO_RANGE_LO) & (io_addr <= `IO_RANGE_HI);   // see RQ14

  wire        disp_hit   = (isa_addr_i.adr_hi == `MEM_DISP_HI);   // see RQ14
  wire        bios_hit   = (isa_addr_i.adr_hi == `MEM_BIOS_HI)
                         & (isa_addr_i.adr[16:15] == `MEM_BIOS_MID);
  wire [16:0] mem_addr   = {isa_addr_i.adr, isa_addr_i.byte_lane3_enable_n,
                            isa_addr_i.byte_lane2_enable_n};

  // ****************************************
  // Strobe edges
  // ****************************************

  isa_strobe_t stb_prev_ff;   // Last cycle's strobes, all idle after reset

  // Inputs are synchronous; a one-cycle history gives the edges
  wire smemr_fall = stb_prev_ff.smemr_n & ~isa_strobe_i.smemr_n;
  wire smemw_fall = stb_prev_ff.mem_write_strobe_in_n & ~isa_strobe_i.mem_write_strobe_in_n;
  wire smemw_rise = ~stb_prev_ff.mem_write_strobe_in_n & isa_strobe_i.mem_write_strobe_in_n;
  wire ior_low    = ~isa_strobe_i.ior_n;

  // ****************************************
  // Write buffer
  // ****************************************

  logic        wb_full;    // No room for another posted write
  logic        wb_valid;   // Oldest entry waiting for memory
  wbuf_entry_t wb_head;    // Oldest entry
  logic        wb_push;    // Capture on write strobe rise
  wbuf_entry_t wb_entry;   // Address held from the falling edge plus data now

  logic [16:0] wr_addr_ff;   // Address seen when the write started

  assign wb_entry = '{addr: wr_addr_ff, data: sd_i};

  isa_write_buffer #(
    .DEPTH       (WBUF_DEPTH)
  ) u_wbuf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .push_i      (wb_push),
    .push_data_i (wb_entry),
    .full_o      (wb_full),
    .valid_o     (wb_valid),
    .data_o      (wb_head),
    .pop_i       (dm_wr_done_i)   // see RQ13
  );

  // ****************************************
  // Cycle sequencer
  // ****************************************

  slave_state_t state_ff;      // Current bus cycle
  slave_state_t nxt_state;
  logic         rdy_ff;        // Ready level on the pin
  logic         nxt_rdy;
  logic         rdy_oe_ff;     // Ready pin driven
  logic         nxt_rdy_oe;
  logic [15:0]  sd_ff;         // Data bus output latch
  logic [15:0]  nxt_sd;
  logic         sd_oe_ff;      // Data bus driven
  logic         nxt_sd_oe;
  logic         rd_req_ff;     // One-cycle fetch request
  logic         nxt_rd_req;
  logic         reg_stb_ff;    // One-cycle register read strobe
  logic         nxt_reg_stb;

  // Next-state decode; defaults at the top give every output a value on every path
  always_comb begin
    nxt_state   = state_ff;
    nxt_rdy     = rdy_ff;
    nxt_rdy_oe  = rdy_oe_ff;
    nxt_sd      = sd_ff;
    nxt_sd_oe   = sd_oe_ff;
    nxt_rd_req  = 1'b0;
    nxt_reg_stb = 1'b0;
    wb_push     = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // Released until a cycle of ours starts
        nxt_rdy_oe = 1'b0;
        nxt_sd_oe  = 1'b0;
        if (smemr_fall && disp_hit) begin
          nxt_state  = ST_RD_WAIT;
          nxt_rdy    = 1'b0;   // see RQ2
          nxt_rdy_oe = 1'b1;
          nxt_rd_req = 1'b1;
        end else if (smemr_fall && bios_hit) begin
          nxt_state  = ST_BIOS;
          nxt_rdy    = 1'b1;   // see RQ1
          nxt_rdy_oe = 1'b1;
        end else if (smemw_fall && disp_hit) begin
          nxt_state  = ST_WR;
          nxt_rdy    = ~wb_full;   // see RQ4 see RQ5
          nxt_rdy_oe = 1'b1;
        end else if (ior_low && io_range) begin
          nxt_state   = ST_IO_RD;
          nxt_rdy     = 1'b1;   // see RQ1
          nxt_rdy_oe  = 1'b1;
          nxt_reg_stb = 1'b1;
        end
      end
      ST_RD_WAIT: begin
        // Host sits in wait states meanwhile
        if (isa_strobe_i.smemr_n) begin
          nxt_state  = ST_IDLE;   // Aborted cycle: let go
          nxt_rdy_oe = 1'b0;
        end else if (dm_rd_valid_i) begin
          nxt_state = ST_RD_HOLD;
          nxt_sd    = dm_rd_data_i;
          nxt_sd_oe = 1'b1;
          nxt_rdy   = 1'b1;   // see RQ3
        end
      end
      ST_RD_HOLD: begin
        // Hold data and ready until the strobe rises
        if (isa_strobe_i.smemr_n) begin
          nxt_state  = ST_IDLE;
          nxt_rdy_oe = 1'b0;   // see RQ3
          nxt_sd_oe  = 1'b0;
        end
      end
      ST_WR: begin
        // Ready follows buffer room, so a freed slot lifts it
        nxt_rdy = ~wb_full;   // see RQ5
        if (smemw_rise) begin
          wb_push    = 1'b1;   // see RQ12
          nxt_state  = ST_IDLE;
          nxt_rdy_oe = 1'b0;
        end
      end
      ST_BIOS: begin
        // No wait states; the ROM drivers supply the data
        if (isa_strobe_i.smemr_n) begin
          nxt_state  = ST_IDLE;
          nxt_rdy_oe = 1'b0;
        end
      end
      ST_IO_RD: begin
        // Follow the register value while the strobe is low
        nxt_sd    = reg_rd_data_i;   // see RQ10
        nxt_sd_oe = 1'b1;
        if (!ior_low || !io_range) begin
          nxt_state  = ST_IDLE;
          nxt_sd_oe  = 1'b0;
          nxt_rdy_oe = 1'b0;
        end
      end
      default: begin
        nxt_state  = ST_IDLE;
        nxt_rdy_oe = 1'b0;
        nxt_sd_oe  = 1'b0;
      end
    endcase
  end

  // Sequencer and pin registers; reset leaves every pin released
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff    <= ST_IDLE;
      stb_prev_ff <= '1;
      rdy_ff      <= 1'b1;
      rdy_oe_ff   <= 1'b0;
      sd_ff       <= `RST_DATA;
      sd_oe_ff    <= 1'b0;
      rd_req_ff   <= 1'b0;
      reg_stb_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      stb_prev_ff <= isa_strobe_i;
      rdy_ff      <= nxt_rdy;      // see RQ6
      rdy_oe_ff   <= nxt_rdy_oe;   // see RQ14
      sd_ff       <= nxt_sd;
      sd_oe_ff    <= nxt_sd_oe;
      rd_req_ff   <= nxt_rd_req;
      reg_stb_ff  <= nxt_reg_stb;
    end
  end

  // ****************************************
  // Address capture and claim pin
  // ****************************************

  logic        io16_oe_ff;     // Claim pulled low
  logic [9:0]  reg_addr_ff;    // Register address to the groups
  logic [16:0] rd_addr_ff;     // Display fetch address

  // Captured on the start edge; the ISA address may move later
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io16_oe_ff  <= 1'b0;
      reg_addr_ff <= 10'h000;
      rd_addr_ff  <= 17'h00000;
      wr_addr_ff  <= 17'h00000;
    end else begin
      io16_oe_ff  <= io16_hit;   // see RQ7 see RQ8
      reg_addr_ff <= (state_ff == ST_IDLE) ? io_addr : reg_addr_ff;
      rd_addr_ff  <= (state_ff == ST_IDLE) ? mem_addr : rd_addr_ff;
      wr_addr_ff  <= (state_ff == ST_IDLE) ? mem_addr : wr_addr_ff;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sd_o                = sd_ff;
  assign sd_oe_o             = sd_oe_ff;
  assign iochrdy_o           = rdy_ff;
  assign iochrdy_oe_o        = rdy_oe_ff;
  assign io16_claim_out_o    = 1'b0;         // Open collector: level is always low, see RQ7
  assign io16_claim_out_oe_o = io16_oe_ff;
  assign reg_rd_strobe_o     = reg_stb_ff;
  assign reg_rd_addr_o       = reg_addr_ff;
  assign dm_rd_req_o         = rd_req_ff;
  assign dm_rd_addr_o        = rd_addr_ff;
  assign dm_wr_valid_o       = wb_valid;
  assign dm_wr_entry_o       = wb_head;

endmodule : isa_slave_ready_and_io_decode

`default_nettype wire

// File: isa_slave_ready_and_io_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module isa_slave_checker (
  // Clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       rst_i,
  // Watched ports
  input wire isa_slave_pkg::isa_addr_t   isa_addr_i,
  input wire isa_slave_pkg::isa_strobe_t isa_strobe_i,
  input wire logic [15:0]                sd_o,
  input wire logic                       sd_oe_o,
  input wire logic                       iochrdy_o,
  input wire logic                       iochrdy_oe_o,
  input wire logic                       io16_claim_out_o,
  input wire logic                       io16_claim_out_oe_o,
  input wire logic                       dm_rd_req_o,
  input wire logic                       dm_rd_valid_i,
  input wire logic [15:0]                dm_rd_data_i,
  input wire logic                       dm_wr_valid_o
);
  import isa_slave_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] stb_ff;  // Strobe history, idle high
  // Ten-bit I/O address as the bus shows it
  wire logic [9:0] io_a = {isa_addr_i.adr[9:2], isa_addr_i.byte_lane3_enable_n, isa_addr_i.byte_lane2_enable_n};
  wire logic claim = !isa_addr_i.aen && isa_addr_i.adr[16:10] == 7'h00 &&
    (io_a[9:1] inside {9'h1e2, 9'h1e7, 9'h1da, 9'h1ea} || io_a inside {10'h3ba, 10'h3da});
  // Falling strobes while idle; ready not driven means no cycle open
  wire logic rd_go = stb_ff[1] && !isa_strobe_i.smemr_n && isa_addr_i.adr_hi == 7'h05 && !iochrdy_oe_o;
  wire logic wr_go = stb_ff[0] && !isa_strobe_i.mem_write_strobe_in_n && isa_addr_i.adr_hi == 7'h05 && !iochrdy_oe_o;
  wire logic bios_go = stb_ff[1] && !isa_strobe_i.smemr_n && isa_addr_i.adr_hi == 7'h06 &&
    isa_addr_i.adr[16:15] == 2'h0 && !iochrdy_oe_o;
  // Edge detect helper
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) stb_ff <= 3'h7;
    else stb_ff <= isa_strobe_i;
  end
  a_rd_wait_low: assert property (rd_go |=> iochrdy_oe_o && !iochrdy_o && dm_rd_req_o ##1 !dm_rd_req_o)
    else $error("read did not start waiting");
  a_rd_data_up: assert property (!isa_strobe_i.smemr_n && iochrdy_oe_o && !iochrdy_o && dm_rd_valid_i
    |=> iochrdy_o && sd_oe_o && sd_o == $past(dm_rd_data_i)) else $error("read data not presented");
  a_rd_hold_high: assert property (sd_oe_o && !isa_strobe_i.smemr_n |=> iochrdy_o && sd_oe_o)
    else $error("read answer dropped early");
  a_bus_release: assert property (sd_oe_o && isa_strobe_i.smemr_n && isa_strobe_i.ior_n
    |=> !sd_oe_o && !iochrdy_oe_o) else $error("bus not released");
  a_wr_no_wait: assert property (wr_go && !dm_wr_valid_o |=> iochrdy_oe_o && iochrdy_o)
    else $error("write to empty buffer waited");
  a_bios_ready: assert property (bios_go |=> (iochrdy_oe_o && iochrdy_o) [*2])
    else $error("rom read not ready");
  a_io_ready_high: assert property (iochrdy_oe_o && !isa_strobe_i.ior_n |-> iochrdy_o)
    else $error("io read waited");
  a_claim_decode: assert property (##1 io16_claim_out_oe_o == $past(claim))
    else $error("claim decode wrong");
  a_claim_pull_only: assert property (io16_claim_out_o == 1'b0)
    else $error("claim driven high");
  a_idle_quiet: assert property ($past(&isa_strobe_i) |-> !sd_oe_o && !iochrdy_oe_o)
    else $error("driving while idle");
  c_read: cover property (rd_go);
  c_write_busy: cover property (wr_go && dm_wr_valid_o);
  c_bios: cover property (bios_go);
endmodule : isa_slave_checker

bind isa_slave_ready_and_io_decode isa_slave_checker u_chk (.ref_clk_i, .rst_i, .isa_addr_i, .isa_strobe_i,
  .sd_o, .sd_oe_o, .iochrdy_o, .iochrdy_oe_o, .io16_claim_out_o, .io16_claim_out_oe_o, .dm_rd_req_o,
  .dm_rd_valid_i, .dm_rd_data_i, .dm_wr_valid_o);
`default_nettype wire

// File: isa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus host model
// ****************
module isa_host_model (
  // Clock and wire levels
  input wire logic                   clk_i,
  input wire logic                   rdy_i,
  input wire logic [15:0]            sd_i,
  // Host drives
  output isa_slave_pkg::isa_addr_t   addr_o,
  output isa_slave_pkg::isa_strobe_t strb_o,
  output logic [15:0]                sd_o
);
  import isa_slave_pkg::*;
  // Idle bus at time zero
  initial begin
    addr_o = '0;
    strb_o = 3'h7;
    sd_o = 16'h0;
  end
  // One cycle: 0 memory read, 1 memory write, 2 I/O read
  task automatic xfer(input logic [1:0] k, input logic [24:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    addr_o <= a;
    sd_o <= d;
    @(posedge clk_i);
    strb_o <= {k != 2'd2, k != 2'd0, k != 2'd1};
    repeat (3) @(posedge clk_i);
    n = 0;
    // Stretch the cycle while ready is low
    while (rdy_i !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    q = sd_i;
    strb_o <= 3'h7;
    // Data stands one edge past the strobe rise, where the write latch samples it
    @(posedge clk_i);
    sd_o <= ~d;  // Released lines must not keep the old value
    @(posedge clk_i);
  endtask : xfer
endmodule : isa_host_model
`default_nettype wire

// File: tb_isa_slave_ready_and_io_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_isa_slave_ready_and_io_decode;
  import isa_slave_pkg::*;
  logic ref_clk_i, rst_i, sd_oe, rdy, rdy_oe, c16, c16_oe, rstb, rreq, rvalid, wvalid, wdone, stall, seen, low_seen;
  isa_addr_t   adr;
  isa_strobe_t stb;
  logic [15:0] hsd, sd_o, q, d;
  logic [9:0]  raddr;
  logic [16:0] rd_addr, raa;
  logic [31:0] a;
  wbuf_entry_t went, wq[$];
  int          fail_count, n_checks, cyc, seed, cnt, i, k, stb_cnt;
  logic [9:0]  io_tab [12] = '{10'h3c4, 10'h3c5, 10'h3ce, 10'h3cf, 10'h3b4, 10'h3b5, 10'h3d4, 10'h3d5,
                              10'h3ba, 10'h3da, 10'h3c0, 10'h3f8};
  // Wire levels: ready has a pull-up
  wire logic        rdy_w = rdy_oe ? rdy : 1'b1;
  wire logic [15:0] bus = sd_oe ? sd_o : hsd;
  function automatic logic [15:0] mem_val(input logic [16:0] x);
    return x[15:0] ^ 16'h5a3c;
  endfunction : mem_val
  function automatic logic [15:0] reg_val(input logic [9:0] x);
    return {~x[5:0], x};
  endfunction : reg_val
  wire logic [15:0] rdat = reg_val(raddr);
  wire logic [15:0] dm_data = mem_val(raa);
  isa_host_model u_host (.clk_i(ref_clk_i), .rdy_i(rdy_w), .sd_i(bus), .addr_o(adr), .strb_o(stb), .sd_o(hsd));
  isa_slave_ready_and_io_decode #(.WBUF_DEPTH(4)) DUT (.ref_clk_i, .rst_i, .isa_addr_i(adr), .isa_strobe_i(stb),
    .sd_i(bus), .sd_o(sd_o), .sd_oe_o(sd_oe), .iochrdy_o(rdy), .iochrdy_oe_o(rdy_oe), .io16_claim_out_o(c16),
    .io16_claim_out_oe_o(c16_oe), .reg_rd_strobe_o(rstb), .reg_rd_addr_o(raddr), .reg_rd_data_i(rdat),
    .dm_rd_req_o(rreq), .dm_rd_addr_o(rd_addr), .dm_rd_valid_i(rvalid), .dm_rd_data_i(dm_data),
    .dm_wr_valid_o(wvalid), .dm_wr_entry_o(went), .dm_wr_done_i(wdone));
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    ref_clk_i = 0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Memory side: random fetch delay, random drain, stall on demand
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
    if (sd_oe | rdy_oe) seen <= 1'b1;
    if (rdy_oe && !rdy) low_seen <= 1'b1;
    if (rstb === 1'b1) stb_cnt <= stb_cnt + 1;
    rvalid <= (rreq !== 1'b1) && (cnt == 1);
    if (rreq === 1'b1) begin
      cnt <= 1 + {$random(seed)} % 5;
      raa <= rd_addr;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    wdone <= wvalid && !stall && !wdone && ($random(seed) & 1);
    if (wdone === 1'b1) chk(went, wq.pop_front());
  end
  initial begin
    seed = 32'h9df3;
    {rst_i, stall, seen, low_seen, rvalid, wdone, raa, cnt, cyc, fail_count, n_checks, stb_cnt} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Every register group, one in-range plain port, one outside
    for (i = 0; i < 12; i++) begin
      seen <= 1'b0;
      stb_cnt <= 0;
      u_host.xfer(2'd2, {14'h0, io_tab[i], 1'b0}, 16'h0, q);
      if (io_tab[i] < 10'h3e0) chk(q, reg_val(io_tab[i]));
      else chk(seen, 1'b0);
      chk(stb_cnt, io_tab[i] < 10'h3e0);
    end
    // A DMA cycle on a claimed port must be ignored
    seen <= 1'b0;
    stb_cnt <= 0;
    u_host.xfer(2'd2, {14'h0, 10'h3c4, 1'b1}, 16'h0, q);
    chk(seen, 1'b0);
    chk(stb_cnt, 0);
    // Random display reads and writes, rom reads, unmapped cycles
    for (i = 0; i < 60; i++) begin
      a = $random(seed);
      d = $random(seed);
      k = {$random(seed)} % 4;
      seen <= 1'b0;
      case (k)
        0: begin
          u_host.xfer(2'd0, {7'h05, a[16:0], 1'b0}, d, q);
          chk(q, mem_val(a[16:0]));
        end
        1: begin
          wq.push_back({a[16:0], d});
          u_host.xfer(2'd1, {7'h05, a[16:0], 1'b0}, d, q);
        end
        2: u_host.xfer(2'd0, {7'h06, 2'h0, a[14:0], 1'b0}, d, q);
        default: begin
          u_host.xfer({1'b0, a[20]}, {4'h8, a[19:0], 1'b0}, d, q);
          chk(seen, 1'b0);
        end
      endcase
    end
    // Drain what is left, then stall it; the fifth posted write must wait
    for (i = 0; i < 100 && wvalid !== 1'b0; i++) @(posedge ref_clk_i);
    stall <= 1'b1;
    low_seen <= 1'b0;
    fork
      for (int j = 0; j < 5; j++) begin
        wq.push_back({17'(j), 16'hc0de ^ 16'(j)});
        u_host.xfer(2'd1, {7'h05, 17'(j), 1'b0}, 16'hc0de ^ 16'(j), q);
      end
      begin
        repeat (120) @(posedge ref_clk_i);
        stall <= 1'b0;
      end
    join
    chk(low_seen, 1'b1);
    for (i = 0; i < 200 && wvalid !== 1'b0; i++) @(posedge ref_clk_i);
    repeat (2) @(posedge ref_clk_i);
    chk(wq.size(), 0);
    close_out();
  end
endmodule : tb_isa_slave_ready_and_io_decode
`default_nettype wire
